/* bench/bdm_core_model.sv */
// Execution datapath model that issues file accesses to the register file
`timescale 1ns/1ps

module bdm_core_model (
    // Clock
    input wire logic clk,
    // Access request
    output logic acc_valid,
    output logic acc_write,
    output logic acc_indirect,
    output logic [6:0] acc_addr,
    output bdm_pkg::bdm_op_t acc_op,
    output logic acc_flags_en,
    output logic [7:0] w_operand,
    output logic [7:0] f_operand,
    // Answer
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    input wire logic [8:0] phys_addr
);
    import bdm_pkg::*;

    initial begin
        acc_valid = 1'b0;
        acc_write = 1'b0;
        acc_indirect = 1'b0;
        acc_addr = 7'h00;
        acc_op = BDM_OP_MOVE;
        acc_flags_en = 1'b0;
        w_operand = 8'h00;
        f_operand = 8'h00;
    end

    // One access: launched after a falling edge, taken at the rising edge
    task automatic access(input logic wr, input logic ind, input logic [6:0] a,
        input bdm_op_t op, input logic fe, input logic [7:0] w, input logic [7:0] f,
        output logic [8:0] pa, output logic rv, output logic [7:0] rd);
        @(negedge clk);
        acc_valid = 1'b1;
        acc_write = wr;
        acc_indirect = ind;
        acc_addr = a;
        acc_op = op;
        acc_flags_en = fe;
        w_operand = w;
        f_operand = f;
        #1;
        pa = phys_addr;
        @(negedge clk);
        acc_valid = 1'b0;
        acc_write = 1'b0;
        // Released operands show the inverse so stale data never matches
        w_operand = ~w;
        f_operand = ~f;
        rv = rd_valid;
        rd = rd_data;
    endtask
endmodule

/* bench/tb_banked_data_memory_status.sv */
// Self-checking testbench for the banked register file and status register
`timescale 1ns/1ps

module tb_banked_data_memory_status;
    import bdm_pkg::*;

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic acc_valid, acc_write, acc_indirect, acc_flags_en;
    logic [6:0] acc_addr;
    bdm_op_t acc_op;
    logic [7:0] w_operand, f_operand, rd_data, status, indirect_pointer, rd;
    logic wdt_clear_evt = 1'b0;
    logic sleep_evt = 1'b0;
    logic wdt_timeout_evt = 1'b0;
    logic rd_valid, rv;
    logic [8:0] phys_addr, pa;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;

    // ----------------------------------------------------------------
    // Clock, design and datapath model
    // ----------------------------------------------------------------
    always #2 clk = ~clk;

    bdm_regfile #(.GPR_DEPTH(36)) uut (.clk(clk), .reset_n(reset_n), .acc_valid(acc_valid),
        .acc_write(acc_write), .acc_indirect(acc_indirect), .acc_addr(acc_addr),
        .acc_op(acc_op), .acc_flags_en(acc_flags_en), .w_operand(w_operand),
        .f_operand(f_operand), .wdt_clear_evt(wdt_clear_evt), .sleep_evt(sleep_evt),
        .wdt_timeout_evt(wdt_timeout_evt), .rd_valid(rd_valid), .rd_data(rd_data),
        .status(status), .indirect_pointer(indirect_pointer), .phys_addr(phys_addr));

    bdm_core_model model (.clk(clk), .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_indirect(acc_indirect), .acc_addr(acc_addr), .acc_op(acc_op),
        .acc_flags_en(acc_flags_en), .w_operand(w_operand), .f_operand(f_operand),
        .rd_valid(rd_valid), .rd_data(rd_data), .phys_addr(phys_addr));

    // ----------------------------------------------------------------
    // Access and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic wr, input logic ind, input logic [6:0] a, input bdm_op_t op,
        input logic fe, input logic [7:0] w, input logic [7:0] f);
        model.access(wr, ind, a, op, fe, w, f, pa, rv, rd);
    endtask

    // Plain move of a byte into a file, no flag update
    task automatic mv(input logic [6:0] a, input logic [7:0] d);
        acc(1'b1, 1'b0, a, BDM_OP_MOVE, 1'b0, d, 8'h00);
    endtask

    // Write status through a pointer aimed at 83h; banks 2 and 3 hide it from direct access
    task automatic mvi(input logic [7:0] d);
        acc(1'b1, 1'b1, 7'h00, BDM_OP_MOVE, 1'b0, d, 8'h00);
    endtask

    // Read a file and compare the answer
    task automatic rdf(input logic ind, input logic [6:0] a, input logic [7:0] exp);
        acc(1'b0, ind, a, BDM_OP_MOVE, 1'b0, 8'h00, 8'h00);
        chk({rv, rd}, {1'b1, exp});
    endtask

    task automatic alu(input logic [6:0] a, input bdm_op_t op, input logic [7:0] w,
        input logic [7:0] f);
        acc(1'b1, 1'b0, a, op, 1'b1, w, f);
    endtask

    // One-cycle core event pulse: 0 clear, 1 sleep, 2 time-out
    task automatic ev(input int k);
        @(negedge clk);
        wdt_clear_evt = (k == 0);
        sleep_evt = (k == 1);
        wdt_timeout_evt = (k == 2);
        @(negedge clk);
        {wdt_clear_evt, sleep_evt, wdt_timeout_evt} = 3'b000;
    endtask

    task automatic stop_test();
        if (failures == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Hang guard: the sequence needs about 110 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            stop_test();
        end
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        chk({1'b0, status}, 9'h018);
        chk({1'b0, indirect_pointer}, 9'h000);
        // RAM edges and unbuilt places
        mv(7'h0C, 8'hA5);
        rdf(1'b0, 7'h0C, 8'hA5);
        mv(7'h2F, 8'h5A);
        rdf(1'b0, 7'h2F, 8'h5A);
        rdf(1'b0, 7'h30, 8'h00);
        mv(7'h7F, 8'h33);
        rdf(1'b0, 7'h7F, 8'h00);
        // Bank 1 view of status and RAM
        mv(7'h03, 8'h20);
        chk({1'b0, status}, 9'h038);
        rdf(1'b0, 7'h0C, 8'hA5);
        chk(pa, 9'h08C);
        rdf(1'b0, 7'h03, 8'h38);
        mv(7'h03, 8'h00);
        // Direct bank map for every select code
        mv(7'h04, 8'h83);
        for (int i = 0; i < 4; i++) begin
            mvi({1'b0, i[1:0], 5'h00});
            chk({1'b0, status}, {2'b00, i[1:0], 5'h18});
            rdf(1'b0, 7'h0C, (i < 2) ? 8'hA5 : 8'h00);
            chk(pa, 9'h00C + 9'(i) * 9'h080);
        end
        mvi(8'h00);
        chk({1'b0, status}, 9'h018);
        // Indirect access through the pointer, both halves
        mv(7'h04, 8'h2F);
        mv(7'h03, 8'h20);
        rdf(1'b0, 7'h04, 8'h2F);
        mv(7'h03, 8'h00);
        rdf(1'b1, 7'h00, 8'h5A);
        chk(pa, 9'h02F);
        mv(7'h03, 8'h80);
        rdf(1'b0, 7'h00, 8'h00);
        chk(pa, 9'h12F);
        mv(7'h03, 8'h00);
        // Arithmetic flags
        alu(7'h0C, BDM_OP_ADD, 8'h0F, 8'h01);
        chk({6'h00, status[2:0]}, 9'h002);
        alu(7'h0C, BDM_OP_ADD, 8'hFF, 8'h01);
        chk({6'h00, status[2:0]}, 9'h007);
        alu(7'h0C, BDM_OP_SUB, 8'h03, 8'h05);
        chk({6'h00, status[2:0]}, 9'h003);
        alu(7'h0C, BDM_OP_SUB, 8'h05, 8'h03);
        chk({6'h00, status[2:0]}, 9'h000);
        alu(7'h0C, BDM_OP_RRF, 8'h00, 8'h01);
        chk({8'h00, status[0]}, 9'h001);
        alu(7'h0C, BDM_OP_RLF, 8'h00, 8'h00);
        chk({8'h00, status[0]}, 9'h000);
        alu(7'h0C, BDM_OP_RLF, 8'h00, 8'h80);
        chk({8'h00, status[0]}, 9'h001);
        // Flag op aimed at status keeps data off the flag bits
        alu(7'h0C, BDM_OP_SUB, 8'h05, 8'h03);
        alu(7'h03, BDM_OP_AND, 8'h07, 8'h07);
        chk({1'b0, status}, 9'h018);
        // Clearing status
        mv(7'h03, 8'h21);
        alu(7'h03, BDM_OP_CLR, 8'h00, 8'h00);
        chk({1'b0, status}, 9'h01D);
        // Reset flags follow core events, never software
        ev(1);
        chk({7'h00, status[4:3]}, 9'h002);
        ev(0);
        chk({7'h00, status[4:3]}, 9'h003);
        ev(2);
        chk({7'h00, status[4:3]}, 9'h001);
        mv(7'h03, 8'h10);
        chk({1'b0, status}, 9'h008);
        ev(1);
        chk({7'h00, status[4:3]}, 9'h002);
        stop_test();
    end
endmodule

/* hw/bdm_defs.svh */
// Constants for the banked data memory and core status register
`ifndef BDM_DEFS_SVH
`define BDM_DEFS_SVH

// ----------------------------------------------------------------
// File addresses within a bank
// ----------------------------------------------------------------
`define BDM_ADDR_INDIRECT 7'h00
`define BDM_ADDR_STATUS 7'h03
`define BDM_ADDR_POINTER 7'h04
`define BDM_GPR_FIRST 7'h0C
`define BDM_GPR_LAST 7'h2F
`define BDM_BANK_LAST 7'h7F
`define BDM_STATUS_MIRROR 9'h083

// ----------------------------------------------------------------
// Bank base addresses
// ----------------------------------------------------------------
`define BDM_BANK0_BASE 9'h000
`define BDM_BANK1_BASE 9'h080
`define BDM_BANK2_BASE 9'h100
`define BDM_BANK3_BASE 9'h180

// ----------------------------------------------------------------
// Status register fields and reset values
// ----------------------------------------------------------------
`define BDM_BIT_IND_BANK 7
`define BDM_BIT_BANK_HIGH 6
`define BDM_BIT_BANK_LOW 5
`define BDM_BIT_WDT 4
`define BDM_BIT_PD 3
`define BDM_BIT_ZERO 2
`define BDM_BIT_NIBBLE 1
`define BDM_BIT_MSB 0
`define BDM_STATUS_RESET 8'h18
`define BDM_POINTER_RESET 8'h00

`endif

/* hw/bdm_flag_alu.sv */
// Result and flag logic for operations that target the register file
`timescale 1ns/1ps

module bdm_flag_alu (
    // Operation and operands
    input wire bdm_pkg::bdm_op_t op,
    input wire logic [7:0] w_operand,
    input wire logic [7:0] f_operand,
    input wire logic carry_in,
    // Result and flags
    output logic [7:0] result,
    output logic flag_z,
    output logic flag_dc,
    output logic flag_c,
    output logic upd_z,
    output logic upd_dc,
    output logic upd_c
);
    import bdm_pkg::*;

    logic [8:0] sum;
    logic [4:0] nib;

    // ----------------------------------------------------------------
    // Result and flag selection
    // ----------------------------------------------------------------
    // Subtraction adds the two's complement, so the carries read as not-borrow
    always_comb begin
        sum = 9'h000;
        nib = 5'h00;
        result = f_operand;
        flag_dc = 1'b0;
        flag_c = 1'b0;
        upd_z = 1'b1;
        upd_dc = 1'b0;
        upd_c = 1'b0;
        unique case (op)
            BDM_OP_MOVE: begin
                result = w_operand;
                upd_z = 1'b0;
            end
            BDM_OP_SWAP: begin
                result = {f_operand[3:0], f_operand[7:4]};
                upd_z = 1'b0;
            end
            BDM_OP_ADD: begin
                sum = {1'b0, f_operand} + {1'b0, w_operand};
                nib = {1'b0, f_operand[3:0]} + {1'b0, w_operand[3:0]};
                result = sum[7:0];
                flag_c = sum[8];
                flag_dc = nib[4];
                upd_dc = 1'b1;
                upd_c = 1'b1;
            end
            BDM_OP_SUB: begin
                sum = {1'b0, f_operand} + {1'b0, ~w_operand} + 9'h001;
                nib = {1'b0, f_operand[3:0]} + {1'b0, ~w_operand[3:0]} + 5'h01;
                result = sum[7:0];
                flag_c = sum[8];
                flag_dc = nib[4];
                upd_dc = 1'b1;
                upd_c = 1'b1;
            end
            BDM_OP_AND: result = f_operand & w_operand;
            BDM_OP_IOR: result = f_operand | w_operand;
            BDM_OP_XOR: result = f_operand ^ w_operand;
            BDM_OP_RRF: begin
                result = {carry_in, f_operand[7:1]};
                flag_c = f_operand[0];
                upd_z = 1'b0;
                upd_c = 1'b1;
            end
            BDM_OP_RLF: begin
                result = {f_operand[6:0], carry_in};
                flag_c = f_operand[7];
                upd_z = 1'b0;
                upd_c = 1'b1;
            end
            BDM_OP_CLR: result = 8'h00;
            default: begin
                result = f_operand;
                upd_z = 1'b0;
            end
        endcase
        flag_z = (result == 8'h00);
    end

endmodule

/* hw/bdm_pkg.sv */
// Types shared by the data memory block and its flag logic
package bdm_pkg;

    // ----------------------------------------------------------------
    // Operation applied to the file operand
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        BDM_OP_MOVE = 4'h0,
        BDM_OP_SWAP = 4'h1,
        BDM_OP_ADD = 4'h2,
        BDM_OP_SUB = 4'h3,
        BDM_OP_AND = 4'h4,
        BDM_OP_IOR = 4'h5,
        BDM_OP_XOR = 4'h6,
        BDM_OP_RRF = 4'h7,
        BDM_OP_RLF = 4'h8,
        BDM_OP_CLR = 4'h9
    } bdm_op_t;

    // ----------------------------------------------------------------
    // What a physical file address decodes to
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        BDM_RGN_NONE = 2'h0,
        BDM_RGN_STATUS = 2'h1,
        BDM_RGN_POINTER = 2'h2,
        BDM_RGN_GPR = 2'h3
    } bdm_region_t;

endpackage

/* hw/bdm_regfile.sv */
// Banked data memory decode, general purpose RAM and the core status register
`timescale 1ns/1ps
`include "bdm_defs.svh"

module bdm_regfile #(
    parameter int GPR_DEPTH = 36
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // File access from the execution datapath
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic acc_indirect,
    input wire logic [6:0] acc_addr,
    // Operation whose result is written back
    input wire bdm_pkg::bdm_op_t acc_op,
    input wire logic acc_flags_en,
    input wire logic [7:0] w_operand,
    input wire logic [7:0] f_operand,
    // Core events
    input wire logic wdt_clear_evt,
    input wire logic sleep_evt,
    input wire logic wdt_timeout_evt,
    // Read answer
    output logic rd_valid,
    output logic [7:0] rd_data,
    // Status view
    output logic [7:0] status,
    output logic [7:0] indirect_pointer,
    output logic [8:0] phys_addr
);
    import bdm_pkg::*;

    logic [7:0] gpr_mem [GPR_DEPTH];
    logic use_ind;
    bdm_region_t region;
    logic [7:0] alu_result;
    logic alu_z;
    logic alu_dc;
    logic alu_c;
    logic upd_z;
    logic upd_dc;
    logic upd_c;
    logic wr_en;
    logic flag_op;
    logic [7:0] next_status;
    logic [5:0] gpr_idx;

    // ----------------------------------------------------------------
    // Address helpers
    // ----------------------------------------------------------------
    // Base address of a bank from its two select bits
    function automatic logic [8:0] bank_base(input logic [1:0] sel);
        unique case (sel)
            2'b11: bank_base = `BDM_BANK3_BASE;
            2'b10: bank_base = `BDM_BANK2_BASE;
            2'b01: bank_base = `BDM_BANK1_BASE;
            default: bank_base = `BDM_BANK0_BASE;
        endcase
    endfunction

    // Only banks 0 and 1 are built; bank 1 shares the bank 0 registers and RAM
    function automatic bdm_region_t decode(input logic [8:0] a);
        if (a[8] || a[6:0] == `BDM_ADDR_INDIRECT) begin
            decode = BDM_RGN_NONE;
        end else if (a[6:0] == `BDM_ADDR_STATUS) begin
            decode = BDM_RGN_STATUS;
        end else if (a[6:0] == `BDM_ADDR_POINTER) begin
            decode = BDM_RGN_POINTER;
        end else if (a[6:0] >= `BDM_GPR_FIRST && a[6:0] <= `BDM_GPR_LAST) begin
            decode = BDM_RGN_GPR;
        end else begin
            decode = BDM_RGN_NONE;
        end
    endfunction

    // ----------------------------------------------------------------
    // Address formation
    // ----------------------------------------------------------------
    // Offset 00h is not a register; it redirects the access through the pointer
    assign use_ind = acc_indirect || (acc_addr == `BDM_ADDR_INDIRECT);
    assign phys_addr = use_ind
        ? {status[`BDM_BIT_IND_BANK], indirect_pointer}
        : bank_base(status[`BDM_BIT_BANK_HIGH:`BDM_BIT_BANK_LOW]) | {2'b00, acc_addr};
    assign region = decode(phys_addr);
    assign gpr_idx = 6'(phys_addr[6:0] - `BDM_GPR_FIRST);
    assign wr_en = acc_valid && acc_write;

    // ----------------------------------------------------------------
    // Result and flag logic
    // ----------------------------------------------------------------
    bdm_flag_alu u_flag_alu (
        .op(acc_op),
        .w_operand(w_operand),
        .f_operand(f_operand),
        .carry_in(status[`BDM_BIT_MSB]),
        .result(alu_result),
        .flag_z(alu_z),
        .flag_dc(alu_dc),
        .flag_c(alu_c),
        .upd_z(upd_z),
        .upd_dc(upd_dc),
        .upd_c(upd_c)
    );

    assign flag_op = acc_valid && acc_flags_en && (upd_z || upd_dc || upd_c);

    // ----------------------------------------------------------------
    // Status next value
    // ----------------------------------------------------------------
    // A flag-affecting op blocks the data write to all three flags, so a clear
    // of status leaves the carries untouched
    always_comb begin
        next_status = status;
        if (wr_en && region == BDM_RGN_STATUS) begin
            next_status[7:5] = alu_result[7:5];
            if (!flag_op) begin
                next_status[2:0] = alu_result[2:0];
            end
        end
        if (flag_op && upd_z) begin
            next_status[`BDM_BIT_ZERO] = alu_z;
        end
        if (flag_op && upd_dc) begin
            next_status[`BDM_BIT_NIBBLE] = alu_dc;
        end
        if (flag_op && upd_c) begin
            next_status[`BDM_BIT_MSB] = alu_c;
        end
        // Reset flags follow core events only; timeout wins over a clear
        if (wdt_clear_evt) begin
            next_status[`BDM_BIT_WDT] = 1'b1;
            next_status[`BDM_BIT_PD] = 1'b1;
        end
        if (sleep_evt) begin
            next_status[`BDM_BIT_WDT] = 1'b1;
            next_status[`BDM_BIT_PD] = 1'b0;
        end
        if (wdt_timeout_evt) begin
            next_status[`BDM_BIT_WDT] = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Status register
    // ----------------------------------------------------------------
    // Power-up leaves both reset flags set
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status <= `BDM_STATUS_RESET;
        end else begin
            status <= next_status;
        end
    end

    // ----------------------------------------------------------------
    // Indirect pointer register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            indirect_pointer <= `BDM_POINTER_RESET;
        end else if (wr_en && region == BDM_RGN_POINTER) begin
            indirect_pointer <= alu_result;
        end
    end

    // ----------------------------------------------------------------
    // General purpose RAM
    // ----------------------------------------------------------------
    // No reset on the array: RAM content is undefined after power-up
    always_ff @(posedge clk) begin
        if (wr_en && region == BDM_RGN_GPR) begin
            gpr_mem[gpr_idx] <= alu_result;
        end
    end

    // ----------------------------------------------------------------
    // Read answer, one cycle after the request
    // ----------------------------------------------------------------
    // Unbuilt locations read as zero
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
        end else begin
            rd_valid <= acc_valid && !acc_write;
            if (acc_valid && !acc_write) begin
                unique case (region)
                    BDM_RGN_STATUS: rd_data <= status;
                    BDM_RGN_POINTER: rd_data <= indirect_pointer;
                    BDM_RGN_GPR: rd_data <= gpr_mem[gpr_idx];
                    BDM_RGN_NONE: rd_data <= 8'h00;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_sleep;
        sleep_evt && !wdt_timeout_evt && !wdt_clear_evt;
    endsequence

    sequence s_status_move;
        wr_en && !flag_op && phys_addr == `BDM_STATUS_MIRROR;
    endsequence

    sequence s_status_clear;
        wr_en && region == BDM_RGN_STATUS && acc_op == BDM_OP_CLR && acc_flags_en;
    endsequence

    AST_DIRECT_BANK: assert property (acc_valid && !use_ind |->
        phys_addr[8:7] == status[6:5] && phys_addr[6:0] == acc_addr)
        else $error("direct access formed the wrong bank");

    AST_INDIRECT_BANK: assert property (acc_valid && use_ind |->
        phys_addr == {status[7], indirect_pointer})
        else $error("indirect access formed the wrong address");

    AST_STATUS_MIRROR: assert property (s_status_move ##1 !wr_en
        |-> status[7:5] == $past(alu_result[7:5]) && status[2:0] == $past(alu_result[2:0]))
        else $error("write at the mirror address missed status");

    AST_RESET_FLAGS_PROTECT: assert property (!wdt_clear_evt && !sleep_evt
        && !wdt_timeout_evt |=> $stable(status[4:3]))
        else $error("reset flags changed without an event");

    AST_STATUS_CLEAR: assert property (s_status_clear and (!wdt_clear_evt && !sleep_evt
        && !wdt_timeout_evt) |=> status[7:5] == 3'b000 && status[2] && status[1:0] ==
        $past(status[1:0]) && status[4:3] == $past(status[4:3]))
        else $error("clearing status gave the wrong pattern");

    AST_SUB_NO_BORROW: assert property (acc_valid && acc_flags_en && acc_op == BDM_OP_SUB
        |=> status[0] == ($past(f_operand) >= $past(w_operand)))
        else $error("subtract carry does not mean no borrow");

    AST_ROTATE_RIGHT: assert property (acc_valid && acc_flags_en && acc_op == BDM_OP_RRF
        |=> status[0] == $past(f_operand[0]))
        else $error("rotate right loaded the wrong carry");

    AST_ADD_ZERO: assert property (acc_valid && acc_flags_en && acc_op == BDM_OP_ADD
        |=> status[2] == (8'($past(f_operand) + $past(w_operand)) == 8'h00))
        else $error("zero flag does not match the sum");

    AST_SLEEP_FLAGS: assert property (s_sleep |=> status[4:3] == 2'b10)
        else $error("sleep did not set the reset flags");

    AST_READ_ANSWER: assert property (acc_valid && !acc_write
        && region == BDM_RGN_NONE |=> rd_valid && rd_data == 8'h00)
        else $error("unbuilt location did not read zero");

endmodule
